/* File: hdl/gpa_top.sv */
/*
  Six-bit port A: direction, latch and pin-level registers, analog pin
  selection, LED and timer clock sharing, pull-up enables for other ports.
  Assumes a classic Wishbone master on CLK_I and asynchronous pad inputs.
*/
`include "gpa_params.svh"

module gpa_top #(
  parameter bit HAS_PORT_J = 1'b1
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Pads
  input wire gpa_pkg::gpa_pins_t PA_IN_I,
  output gpa_pkg::gpa_pins_t PA_OUT_O,
  output gpa_pkg::gpa_pins_t PA_OE_N_O,
  // Ethernet LED sources
  input wire logic LED_A_I,
  input wire logic LED_B_I,
  // Alternate functions
  output logic TMR0_CLK_O,
  output gpa_pkg::gpa_analog_s ANALOG_O,
  output gpa_pkg::gpa_pullup_s PULLUP_O
);

  // ==========================================================
  // Registers
  // ==========================================================

  gpa_pkg::gpa_pins_t pin_s1_r;
  gpa_pkg::gpa_pins_t pin_s2_r;
  gpa_pkg::gpa_pins_t lat_r;
  gpa_pkg::gpa_pins_t dir_r;
  logic [5:0] acfg_r;
  logic [1:0] ctrl_r;
  logic pu_j_r;
  logic pu_d_r;
  logic pu_e_r;
  logic ack_r;
  logic [7:0] dat_r;
  gpa_pkg::gpa_pins_t out_r;
  gpa_pkg::gpa_pins_t oe_n_r;

  // ==========================================================
  // Bus decode
  // ==========================================================

  wire req = CYC_I & STB_I;
  wire [5:0] widx = ADR_I[7:2];
  wire hit_lev = (widx == `GPA_IDX_LEVELS);
  wire hit_lat = (widx == `GPA_IDX_LATCH);
  wire hit_dir = (widx == `GPA_IDX_DIR);
  wire hit_acfg = (widx == `GPA_IDX_ACFG);
  wire hit_ctrl = (widx == `GPA_IDX_CTRL);
  // A write lands on the edge where the master sees ACK_O.
  wire wr_go = req & WE_I & ack_r & SEL_I[0];
  wire [7:0] wd = DAT_I[7:0];

  // ==========================================================
  // Analog selection
  // ==========================================================

  wire led_en = ctrl_r[`GPA_BIT_LED_EN];
  wire cref_out_en = ctrl_r[`GPA_BIT_CREF_OUT_EN];
  wire ref_lo = acfg_r[`GPA_BIT_REF_LO];
  wire ref_hi = acfg_r[`GPA_BIT_REF_HI];
  logic [4:0] ch_en;

  // Lower channels stay analog longest as the field value rises.
  for (genvar k = 0; k < 5; k++) begin : g_ch
    assign ch_en[k] = (acfg_r[3:0] < (`GPA_ANA_LIMIT - 4'(k)));
  end

  // Pin 4 has no analog role and stays a Schmitt digital input.
  gpa_pkg::gpa_pins_t pin_ana;
  assign pin_ana[0] = ch_en[0];
  assign pin_ana[1] = ch_en[1];
  assign pin_ana[2] = ch_en[2] | ref_lo;
  assign pin_ana[3] = ch_en[3] | ref_hi;
  assign pin_ana[4] = 1'b0;
  assign pin_ana[5] = ch_en[4];

  wire [5:0] cv_mask = {3'h0, cref_out_en, 2'h0};
  wire [5:0] dig_in_en = ~pin_ana & ~cv_mask;

  assign ANALOG_O.ch_en = ch_en;
  assign ANALOG_O.cmp_plus_en = ch_en[2] & ~ref_lo;
  assign ANALOG_O.vref_lo_en = ref_lo;
  assign ANALOG_O.vref_hi_en = ref_hi;
  assign ANALOG_O.cref_out_en = cref_out_en;

  // ==========================================================
  // Output drive
  // ==========================================================

  gpa_pkg::gpa_pins_t out_nxt;
  wire [1:0] led = {LED_B_I, LED_A_I};

  // Analog selection never touches this path, so an analog pin still drives.
  for (genvar i = 0; i < 6; i++) begin : g_drv
    if (i < 2) begin : g_led
      assign out_nxt[i] = led_en ? led[i] : lat_r[i];
    end else begin : g_lat
      assign out_nxt[i] = lat_r[i];
    end
  end

  // The driver is released for an input and while pin 2 carries the reference.
  wire [5:0] oe_n_nxt = dir_r | cv_mask;

  // ==========================================================
  // Read data
  // ==========================================================

  wire pu_j_q = pu_j_r & HAS_PORT_J;
  wire [7:0] lev_rd = {pu_j_q, 1'b0, pin_s2_r & dig_in_en};
  wire [7:0] lat_rd = {pu_d_r, pu_e_r, lat_r};
  wire [7:0] dir_rd = {2'h0, dir_r};
  wire [7:0] acfg_rd = {2'h0, acfg_r};
  wire [7:0] ctrl_rd = {6'h00, ctrl_r};
  wire [7:0] rd_byte = hit_lev ? lev_rd :
                       hit_lat ? lat_rd :
                       hit_dir ? dir_rd :
                       hit_acfg ? acfg_rd :
                       hit_ctrl ? ctrl_rd : 8'h00;

  // ==========================================================
  // Pad synchroniser and timer clock
  // ==========================================================

  always_ff @(posedge CLK_I) begin
    pin_s1_r <= PA_IN_I;
    pin_s2_r <= pin_s1_r;
  end

  // The timer sees pin 4 whatever its direction bit holds.
  assign TMR0_CLK_O = pin_s2_r[4];

  // ==========================================================
  // Bus handshake
  // ==========================================================

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_r <= 1'b0;
      dat_r <= 8'h00;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= rd_byte;
      end
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = {24'h000000, dat_r};

  // ==========================================================
  // Register file
  // ==========================================================

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      lat_r <= `GPA_LAT_RST;
      dir_r <= `GPA_DIR_RST;
      acfg_r <= `GPA_ACFG_RST;
      ctrl_r <= `GPA_CTRL_RST;
      pu_j_r <= 1'b0;
      pu_d_r <= 1'b0;
      pu_e_r <= 1'b0;
    end else if (wr_go) begin
      if (hit_lev) begin
        lat_r <= wd[5:0];
        pu_j_r <= wd[`GPA_BIT_PU_J] & HAS_PORT_J;
      end
      if (hit_lat) begin
        lat_r <= wd[5:0];
        pu_d_r <= wd[`GPA_BIT_PU_D];
        pu_e_r <= wd[`GPA_BIT_PU_E];
      end
      if (hit_dir) begin
        dir_r <= wd[5:0];
      end
      if (hit_acfg) begin
        acfg_r <= wd[5:0];
      end
      if (hit_ctrl) begin
        ctrl_r <= wd[1:0];
      end
    end
  end

  assign PULLUP_O.pu_j = pu_j_q;
  assign PULLUP_O.pu_d = pu_d_r;
  assign PULLUP_O.pu_e = pu_e_r;

  // ==========================================================
  // Pad drive registers
  // ==========================================================

  // Registered so pads never glitch on decode; costs one cycle of latency.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      out_r <= 6'h00;
      oe_n_r <= 6'h3F;
    end else begin
      out_r <= out_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign PA_OUT_O = out_r;
  assign PA_OE_N_O = oe_n_r;

  // ==========================================================
  // Assertions
  // ==========================================================

  default clocking cb @(posedge CLK_I);
  endclocking

  default disable iff (SRST_I);

  property p_drive_latch;
    !dir_r[5] |=> !PA_OE_N_O[5] && (PA_OUT_O[5] == $past(lat_r[5]));
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("pin 5 output does not follow its latch");

  property p_ana_read;
    req && !ack_r && !WE_I && hit_lev && pin_ana[0] |=> ACK_O && !DAT_O[0];
  endproperty
  a_ana_read: assert property (p_ana_read)
    else $error("analog pin 0 read back as one");

  property p_led;
    led_en && !dir_r[0] |=> PA_OUT_O[0] == $past(LED_A_I);
  endproperty
  a_led: assert property (p_led)
    else $error("pin 0 does not carry LED A");

  property p_reset_analog;
    $fell(SRST_I) |-> ch_en == 5'h1F && dir_r == 6'h3F && !PULLUP_O.pu_d;
  endproperty
  a_reset_analog: assert property (p_reset_analog)
    else $error("reset state of port is wrong");

  property p_cmp_plus;
    acfg_r[3:0] == 4'h0 && !ref_lo |-> ANALOG_O.cmp_plus_en && ANALOG_O.ch_en[2];
  endproperty
  a_cmp_plus: assert property (p_cmp_plus)
    else $error("comparator plus input not fed by pin 2");

  property p_cref_out;
    cref_out_en |-> !lev_rd[2] ##1 PA_OE_N_O[2];
  endproperty
  a_cref_out: assert property (p_cref_out)
    else $error("pin 2 digital path active with reference out");

  // The first two samples after reset still see pads from before they were defined.
  property p_timer;
    !$past(SRST_I, 2) |-> TMR0_CLK_O == $past(PA_IN_I[4], 2);
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer clock does not follow pin 4");

  property p_level_write;
    wr_go && hit_lev |=> lat_r == $past(DAT_I[5:0]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("level register write missed the latch");

  property p_reserved;
    ACK_O && !WE_I && (hit_dir || hit_acfg) |-> DAT_O[31:6] == 26'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("unimplemented bits read nonzero");

  property p_pullup;
    wr_go && hit_lat |=> PULLUP_O.pu_d == $past(DAT_I[7]);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("port D pull-up enable not written");

  property p_ack;
    req && !ack_r |=> ACK_O ##1 !ACK_O;
  endproperty
  a_ack: assert property (p_ack)
    else $error("acknowledge is not a single cycle pulse");

  property p_pu_j_write;
    wr_go && hit_lev |=> PULLUP_O.pu_j == ($past(DAT_I[7]) && HAS_PORT_J);
  endproperty
  a_pu_j_write: assert property (p_pu_j_write)
    else $error("port J pull-up enable does not follow the write");

  property p_reset_pads;
    $fell(SRST_I) |-> PA_OE_N_O == 6'h3F && PULLUP_O == 3'h0;
  endproperty
  a_reset_pads: assert property (p_reset_pads)
    else $error("pads or pull-ups not released after reset");

  property p_ref_hi_read;
    req && !ack_r && !WE_I && hit_lev && ref_hi |=> !DAT_O[3];
  endproperty
  a_ref_hi_read: assert property (p_ref_hi_read)
    else $error("pin 3 read as digital while it is the high reference");

  property p_pin4_read;
    req && !ack_r && !WE_I && hit_lev |=> DAT_O[4] == $past(pin_s2_r[4]);
  endproperty
  a_pin4_read: assert property (p_pin4_read)
    else $error("pin 4 digital read is blocked");

  property p_led_b;
    led_en && !dir_r[1] |=> PA_OUT_O[1] == $past(LED_B_I);
  endproperty
  a_led_b: assert property (p_led_b)
    else $error("pin 1 does not carry LED B");

  property p_analog_drive;
    pin_ana[0] && !dir_r[0] && !led_en |=> !PA_OE_N_O[0] && PA_OUT_O[0] == $past(lat_r[0]);
  endproperty
  a_analog_drive: assert property (p_analog_drive)
    else $error("analog mode changed the pin 0 output drive");

  property p_sel_refused;
    req && WE_I && ack_r && !SEL_I[0] |=> $stable(lat_r) && $stable(dir_r);
  endproperty
  a_sel_refused: assert property (p_sel_refused)
    else $error("write without byte enable changed a register");

  c_led: cover property (led_en && !dir_r[0] && !PA_OE_N_O[0]);
  c_cref_out: cover property (cref_out_en ##1 PA_OE_N_O[2]);
  c_lev_wr: cover property (wr_go && hit_lev);
  c_digital: cover property (ch_en == 5'h00 && !dir_r[5]);

endmodule : gpa_top

/* File: hdl/gpa_params.svh */
/*
  Constants of the six-bit port A block: word indices, field positions,
  reset values. Assumes a Wishbone slave with 32-bit data words.
*/
// Behaviour
// - Direction 0 drives the pin from its latch bit; analog mode leaves drive alone.
// - Direction 1 makes an input; analog mode blanks the digital read path.
// - LED enable drives pins 0 and 1 with LED A/B when direction is 0.
// - After reset pins 0,1,2,3,5 are analog channels 0..4, digital input off.
// - Pin 2 analog feeds channel 2 and comparator plus, or the low reference.
// - Comparator reference output disables pin 2 digital driver and input.
// - Pin 3 analog is channel 3 or the converter high reference input.
// - Pin 4 is a Schmitt digital input after reset, with no analog function.
// - Pin 4 level always reaches the timer 0 clock input, direction ignored.
// - Writing the pin level register writes the output latch.
// - Unimplemented bits read zero: levels 6, direction 7:6, analog 7:6.
// - Port J pull-up bit exists only in larger variants, else reads zero.
// - Pin level bit 7 enables the port J weak pull-ups.
// - Latch bits 7 and 6 enable port D and port E pull-ups.
// - Four-bit field selects analog or digital for each analog pin.
`ifndef GPA_PARAMS_SVH
`define GPA_PARAMS_SVH

// Word indices; the byte address is four times the index.
`define GPA_IDX_LEVELS 6'h00
`define GPA_IDX_LATCH 6'h01
`define GPA_IDX_DIR 6'h02
`define GPA_IDX_ACFG 6'h03
`define GPA_IDX_CTRL 6'h04

`define GPA_BIT_PU_J 7
`define GPA_BIT_PU_D 7
`define GPA_BIT_PU_E 6
`define GPA_BIT_REF_HI 5
`define GPA_BIT_REF_LO 4
`define GPA_BIT_LED_EN 0
`define GPA_BIT_CREF_OUT_EN 1

`define GPA_DIR_RST 6'h3F
`define GPA_LAT_RST 6'h00
`define GPA_ACFG_RST 6'h00
`define GPA_CTRL_RST 2'h0
`define GPA_ANA_LIMIT 4'h5

`endif

/* File: hdl/gpa_pkg.sv */
/*
  Types of the six-bit port A block.
  Assumes the constants header is included where numbers are needed.
*/
package gpa_pkg;

  typedef logic [5:0] gpa_pins_t;

  typedef struct packed {
    logic pu_j;
    logic pu_d;
    logic pu_e;
  } gpa_pullup_s;

  typedef struct packed {
    logic [4:0] ch_en;
    logic cmp_plus_en;
    logic vref_lo_en;
    logic vref_hi_en;
    logic cref_out_en;
  } gpa_analog_s;

endpackage : gpa_pkg

/* File: tb/gpa_pad_model.sv */
/*
  Pad model of port A: resolves each pin from the block's drive and an outside level.
  Assumes the outside source is weak and loses to any pin the block drives.
*/
module gpa_pad_model (
  // From the block
  input wire gpa_pkg::gpa_pins_t pad_out_i,
  input wire gpa_pkg::gpa_pins_t pad_oe_n_i,
  // Outside source
  input wire gpa_pkg::gpa_pins_t ext_i,
  // Resolved pin level
  output gpa_pkg::gpa_pins_t pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pin shows the outside source; a driven one shows the block's data.
  assign pin_o = (pad_oe_n_i & ext_i) | (~pad_oe_n_i & pad_out_i);
endmodule : gpa_pad_model

/* File: tb/tb_gpa_top.sv */
/*
  Self-checking bench of port A: Wishbone register access, pads, LEDs, pull-ups.
  Assumes the block acknowledges every access within the wait bound of the bus task.
*/
`include "gpa_params.svh"

module tb_gpa_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic CLK_I, SRST_I, cyc, stb, we, led_a, led_b;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, DAT_O, dat2, q, q2;
  logic ACK_O, TMR0_CLK_O, ack_seen;
  gpa_pkg::gpa_pins_t pin, ext, PA_OUT_O, PA_OE_N_O;
  gpa_pkg::gpa_analog_s ANALOG_O;
  gpa_pkg::gpa_pullup_s PULLUP_O;
  int bad_count, check_count, f, k;
  logic [4:0] e;
  localparam logic [7:0] A_LV = {`GPA_IDX_LEVELS, 2'h0};
  localparam logic [7:0] A_LT = {`GPA_IDX_LATCH, 2'h0};
  localparam logic [7:0] A_DR = {`GPA_IDX_DIR, 2'h0};
  localparam logic [7:0] A_AC = {`GPA_IDX_ACFG, 2'h0};
  localparam logic [7:0] A_CT = {`GPA_IDX_CTRL, 2'h0};
  // ==========================================================
  // Instances
  gpa_top DUT (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(DAT_O), .ACK_O(ACK_O), .PA_IN_I(pin),
    .PA_OUT_O(PA_OUT_O), .PA_OE_N_O(PA_OE_N_O), .LED_A_I(led_a), .LED_B_I(led_b),
    .TMR0_CLK_O(TMR0_CLK_O), .ANALOG_O(ANALOG_O), .PULLUP_O(PULLUP_O));
  // The small variant shares the bus so its reads can be compared word for word.
  gpa_top #(.HAS_PORT_J(1'b0)) DUT2 (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat), .DAT_O(dat2),
    .ACK_O(), .PA_IN_I(pin), .PA_OUT_O(), .PA_OE_N_O(), .LED_A_I(led_a),
    .LED_B_I(led_b), .TMR0_CLK_O(), .ANALOG_O(), .PULLUP_O());
  gpa_pad_model pads (.pad_out_i(PA_OUT_O), .pad_oe_n_i(PA_OE_N_O), .ext_i(ext), .pin_o(pin));
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  // ==========================================================
  // Tasks
  task automatic stop_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk_bus(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected read at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk_bus
  task automatic chk_pin(input logic [8:0] g, input logic [8:0] x);
    check_count++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected pin value at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk_pin
  // The request is held until ack is sampled high at a rising edge, then released.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
    @(posedge CLK_I);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    sel <= {3'h0, s};
    ack_seen = 1'b0;
    for (int n = 0; n < 20 && !ack_seen; n++) begin
      @(posedge CLK_I);
      ack_seen = (ACK_O === 1'b1);
    end
    if (!ack_seen) begin
      bad_count++;
      $display("unexpected timeout at %0t: no acknowledge", $time);
      stop_test();
    end
    q = DAT_O;
    q2 = dat2;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00, 1'b1);
    chk_bus(q, {24'h000000, x});
  endtask : rd
  // Pads lag registers by one edge and the read path by two more.
  task automatic nap;
    repeat (4) @(posedge CLK_I);
    @(negedge CLK_I);
  endtask : nap
  // ==========================================================
  // Sequence
  initial begin
    SRST_I = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    ext = 6'h3F;
    led_a = 1'b0;
    led_b = 1'b0;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    nap();
    chk_pin(9'(PA_OE_N_O), 9'(`GPA_DIR_RST));
    chk_pin(ANALOG_O, 9'h1F8);
    chk_pin(9'(PULLUP_O), 9'h000);
    chk_pin(9'(TMR0_CLK_O), 9'h001);
    rd(A_DR, 8'h3F);
    rd(A_LV, 8'h10);
    for (f = 0; f < 6; f++) begin
      wr(A_AC, f[7:0]);
      for (k = 0; k < 5; k++) e[k] = (f < 5 - k);
      nap();
      chk_pin(9'(ANALOG_O.ch_en), 9'(e));
      rd(A_LV, {2'h0, ~{e[4], 1'b0, e[3:0]}});
    end
    wr(A_AC, 8'h10);
    nap();
    chk_pin(ANALOG_O, 9'h1F4);
    wr(A_AC, 8'hFF);
    rd(A_AC, 8'h3F);
    nap();
    chk_pin(ANALOG_O, 9'h006);
    rd(A_LV, 8'h33);
    wr(A_DR, 8'hFF);
    rd(A_DR, 8'h3F);
    wr(A_AC, 8'h00);
    wr(A_DR, 8'h00);
    wr(A_LV, 8'h2A);
    nap();
    chk_pin(9'(PA_OUT_O), 9'h02A);
    chk_pin(9'(PA_OE_N_O), 9'h000);
    rd(A_LT, 8'h2A);
    rd(A_LV, 8'h00);
    wr(A_AC, 8'h0F);
    nap();
    rd(A_LV, 8'h2A);
    wr(A_LT, 8'h10);
    nap();
    chk_pin(9'(TMR0_CLK_O), 9'h001);
    wr(A_DR, 8'h10);
    ext <= 6'h00;
    nap();
    chk_pin(9'(TMR0_CLK_O), 9'h000);
    wr(A_LV, 8'h80);
    rd(A_LV, 8'h80);
    chk_bus(q2, 32'h0);
    chk_pin(9'(PULLUP_O), 9'h004);
    wr(A_LT, 8'hC0);
    nap();
    chk_pin(9'(PULLUP_O), 9'h007);
    rd(A_LT, 8'hC0);
    wb(1'b1, A_LT, 8'h3F, 1'b0);
    rd(A_LT, 8'hC0);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(A_DR, 8'h00);
    wr(A_CT, 8'h01);
    led_a <= 1'b1;
    nap();
    chk_pin(9'(PA_OUT_O[1:0]), 9'h001);
    @(posedge CLK_I);
    led_a <= 1'b0;
    led_b <= 1'b1;
    nap();
    chk_pin(9'(PA_OUT_O[1:0]), 9'h002);
    wr(A_DR, 8'h01);
    nap();
    chk_pin(9'(PA_OE_N_O[0]), 9'h001);
    wr(A_LT, 8'hC4);
    wr(A_CT, 8'h02);
    ext <= 6'h3F;
    nap();
    chk_pin(9'(PA_OE_N_O), 9'h005);
    chk_pin(9'(ANALOG_O.cref_out_en), 9'h001);
    rd(A_LV, 8'h81);
    stop_test();
  end
endmodule : tb_gpa_top
